/* File: hw/hw_event_trace_encoder.sv */
`timescale 1ns/100ps
`include "hw_event_trace_params.svh"
module hw_event_trace_encoder #(
  parameter int         N_EVENTS  = 32,
  parameter int         TS_W      = 32,
  parameter logic       MASTER_RW = 1'b1,
  parameter logic       ERR_IMPL  = 1'b1,
  parameter logic [1:0] COMP_MODE = `HET_COMP_PROG
) (
  input  wire logic                                i_clock,
  input  wire logic                                i_rst,
  input  wire logic                                i_wb_cyc,
  input  wire logic                                i_wb_stb,
  input  wire logic                                i_wb_we,
  input  wire logic [7:0]                          i_wb_adr,
  input  wire logic [3:0]                          i_wb_sel,
  input  wire logic [31:0]                         i_wb_dat,
  output logic      [31:0]                         o_wb_dat,
  output logic                                     o_wb_ack,
  input  wire logic [(N_EVENTS>0?N_EVENTS:1)-1:0]  i_event,
  input  wire logic [TS_W-1:0]                     i_timestamp,
  input  wire logic                                i_pkt_ready,
  output logic                                     o_pkt_valid,
  output hw_event_trace_pkg::pkt_kind_t            o_pkt_kind,
  output hw_event_trace_pkg::pkt_size_t            o_pkt_size,
  output logic      [31:0]                         o_pkt_data,
  output logic                                     o_pkt_ts_valid,
  output logic      [TS_W-1:0]                     o_pkt_ts
);
  import hw_event_trace_pkg::*;

  localparam int NW = (N_EVENTS > 0) ? N_EVENTS : 1;
  localparam int NB = (N_EVENTS > 32) ? (N_EVENTS + 31) / 32 : 1;
  localparam int EV = NB * `HET_BANK_BITS;
  localparam int BW = (NB > 1) ? $clog2(NB) : 1;

  if (N_EVENTS < 0 || N_EVENTS > `HET_MAX_EVENTS || TS_W < 1 || TS_W > 64) begin : g_chk
    $error("event count must be 0..256 and timestamp 1..64 bits");
  end

  logic [15:0]     master_q;
  logic [9:0]      ctrl_q;
  logic            glob_q;
  logic [EV-1:0]   evt_en_q, trig_en_q, impl_mask, ev_pad, set, clr, pending, job_mask_d;
  logic [BW-1:0]   bank_q, pick_bank;
  logic [4:0]      pick_bit;
  logic [NB-1:0]   bank_any, same;
  logic [NB*TS_W-1:0] stamps;
  logic            lost, lost_clr, any_bank, bit_found, active, squeeze, lost_rep;
  logic [31:0]     bank_word, rdata, feat;
  logic [7:0]      adr;
  logic            wr, rd_go;

  state_t          state_q;
  job_t            job_q;
  logic [EV-1:0]   job_mask_q;
  logic [31:0]     job_word_q;
  logic [7:0]      job_chan_q, last_chan_q;
  logic [15:0]     last_master_q;
  logic            job_ts_q, job_marked_q, master_sent_q, chan_sent_q, flag_due_q;
  logic [TS_W-1:0] job_stamp_q;
  logic            free, load, start, master_diff, chan_diff;
  pkt_kind_t       pk_kind;
  pkt_size_t       pk_size;
  logic [31:0]     pk_data;
  logic            pk_tsv;
  logic [TS_W-1:0] pk_ts;

  assign active   = glob_q & ctrl_q[`HET_CTRL_EN];
  assign squeeze  = (COMP_MODE == `HET_COMP_PROG) ? ctrl_q[`HET_CTRL_SQZ]
                                                  : (COMP_MODE == `HET_COMP_ALWAYS);
  assign lost_rep = ERR_IMPL & ctrl_q[`HET_CTRL_LOST];

  always_comb begin
    for (int i = 0; i < EV; i++) begin
      impl_mask[i] = (i < N_EVENTS);
      ev_pad[i]    = (i < N_EVENTS) && i_event[i % NW];
    end
  end
  assign set = ev_pad & evt_en_q & {EV{active}};

  // ---------------- wishbone slave ----------------
  assign adr   = {i_wb_adr[7:2], 2'b00};
  assign wr    = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack;
  assign rd_go = i_wb_cyc & i_wb_stb & ~i_wb_we & ~o_wb_ack;

  always_ff @(posedge i_clock) begin
    if (i_rst) o_wb_ack <= 1'b0;
    else o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
  end

  assign feat = {8'h00, 9'(N_EVENTS), 9'h000, COMP_MODE, MASTER_RW, ERR_IMPL, 1'b0, 1'b1};

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (adr)
      `HET_OFF_CTRL:   rdata[9:0] = ctrl_q;
      `HET_OFF_MASTER: rdata[15:0] = master_q;
      `HET_OFF_FEAT:   rdata = feat;
      `HET_OFF_EVEN:   rdata = evt_en_q[int'(bank_q)*32 +: 32];
      `HET_OFF_TRIG:   rdata = trig_en_q[int'(bank_q)*32 +: 32];
      `HET_OFF_BANK:   if (NB > 1) rdata[BW-1:0] = bank_q;
      `HET_OFF_IDENT:  rdata[3:0] = `HET_IDENT_CLASS;
      `HET_OFF_GLOBAL: rdata[0] = glob_q;
      `HET_OFF_STATUS: rdata = {16'h0000, 8'(bank_any), 6'h00, state_q != ST_IDLE, lost};
      default:         rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) o_wb_dat <= 32'h0000_0000;
    else if (rd_go) o_wb_dat <= rdata;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl_q <= 10'h000;
      glob_q <= 1'b0;
    end else if (wr && adr == `HET_OFF_CTRL) begin
      ctrl_q <= 10'(merge_bytes(32'(ctrl_q), i_wb_dat, i_wb_sel) & 32'h0000_0307);
    end else if (wr && adr == `HET_OFF_GLOBAL && i_wb_sel[0]) begin
      glob_q <= i_wb_dat[0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) master_q <= `HET_MASTER_RESET;
    else if (MASTER_RW && wr && adr == `HET_OFF_MASTER)
      master_q <= 16'(merge_bytes(32'(master_q), i_wb_dat, i_wb_sel));
  end

  // live reprogramming: these writes never wait for tracing to stop
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      evt_en_q  <= '0;
      trig_en_q <= '0;
      bank_q    <= '0;
    end else if (wr) begin
      if (adr == `HET_OFF_EVEN)
        evt_en_q[int'(bank_q)*32 +: 32] <= merge_bytes(evt_en_q[int'(bank_q)*32 +: 32],
          i_wb_dat, i_wb_sel) & impl_mask[int'(bank_q)*32 +: 32];
      if (adr == `HET_OFF_TRIG)
        trig_en_q[int'(bank_q)*32 +: 32] <= merge_bytes(trig_en_q[int'(bank_q)*32 +: 32],
          i_wb_dat, i_wb_sel) & impl_mask[int'(bank_q)*32 +: 32];
      if (NB > 1 && adr == `HET_OFF_BANK && i_wb_sel[0] && int'(i_wb_dat[BW-1:0]) < NB)
        bank_q <= i_wb_dat[BW-1:0];
    end
  end

  // ---------------- event capture and selection ----------------
  event_capture #(.NB(NB), .TS_W(TS_W)) u_capture (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_set       (set),
    .i_clr       (clr),
    .i_lost_clr  (lost_clr),
    .i_timestamp (i_timestamp),
    .o_pending   (pending),
    .o_lost      (lost),
    .o_stamp     (stamps),
    .o_same      (same)
  );

  for (genvar b = 0; b < NB; b++) begin : g_any
    assign bank_any[b] = |pending[b*32 +: 32];
  end

  lowest_set #(.W(NB), .IW(BW)) u_pick_bank (
    .i_vec   (bank_any),
    .o_index (pick_bank),
    .o_found (any_bank)
  );
  assign bank_word = pending[int'(pick_bank)*32 +: 32];
  lowest_set #(.W(32), .IW(5)) u_pick_bit (
    .i_vec   (bank_word),
    .o_index (pick_bit),
    .o_found (bit_found)
  );

  // marked clears one event; plain clears every bit it reports
  always_comb begin
    job_mask_d = '0;
    if (ctrl_q[`HET_CTRL_MARKED]) job_mask_d[int'(pick_bank)*32 + int'(pick_bit)] = bit_found;
    else job_mask_d[int'(pick_bank)*32 +: 32] = bank_word;
  end

  // ---------------- packet sequencer ----------------
  assign free        = ~o_pkt_valid | i_pkt_ready;
  assign load        = free & (state_q != ST_IDLE);
  assign start       = (state_q == ST_IDLE) & active & ((lost & lost_rep) | any_bank | flag_due_q);
  assign master_diff = ~master_sent_q | (last_master_q != master_q);
  assign chan_diff   = ~chan_sent_q | (last_chan_q != job_chan_q);
  assign clr         = (state_q == ST_DATA && free) ? job_mask_q : '0;
  assign lost_clr    = (state_q == ST_ERR) & free;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      job_q        <= JOB_DATA;
      job_mask_q   <= '0;
      job_word_q   <= 32'h0000_0000;
      job_chan_q   <= 8'h00;
      job_ts_q     <= 1'b0;
      job_marked_q <= 1'b0;
      job_stamp_q  <= '0;
    end else if (start) begin
      job_marked_q <= ctrl_q[`HET_CTRL_MARKED];
      job_mask_q   <= job_mask_d;
      job_stamp_q  <= stamps[int'(pick_bank)*TS_W +: TS_W];
      job_ts_q     <= ctrl_q[`HET_CTRL_TS] & same[pick_bank];
      if (lost & lost_rep) job_q <= JOB_ERR;
      else if (any_bank) job_q <= JOB_DATA;
      else job_q <= JOB_FLAG;
      if (ctrl_q[`HET_CTRL_MARKED]) begin
        job_word_q <= {24'h000000, 3'(pick_bank), pick_bit};
        job_chan_q <= 8'h00;
      end else begin
        job_word_q <= bank_word;
        job_chan_q <= 8'(pick_bank);
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: if (start) begin
          if (master_diff) state_q <= ST_MASTER;
          else if (lost & lost_rep) state_q <= ST_ERR;
          else if (any_bank) state_q <= chan_diff_now() ? ST_CHAN : ST_DATA;
          else state_q <= ST_FLAG;
        end
        ST_MASTER: if (free) begin
          unique case (job_q)
            JOB_DATA: state_q <= chan_diff ? ST_CHAN : ST_DATA;
            JOB_FLAG: state_q <= ST_FLAG;
            default:  state_q <= ST_ERR;
          endcase
        end
        ST_CHAN: if (free) state_q <= ST_DATA;
        default: if (free) state_q <= ST_IDLE;
      endcase
    end
  end

  // channel seen from the live pick, before the job registers settle
  function automatic logic chan_diff_now();
    logic [7:0] c;
    c = ctrl_q[`HET_CTRL_MARKED] ? 8'h00 : 8'(pick_bank);
    return ~chan_sent_q | (last_chan_q != c);
  endfunction

  always_ff @(posedge i_clock) begin
    if (i_rst || !active) begin
      master_sent_q <= 1'b0;
      chan_sent_q   <= 1'b0;
      last_master_q <= 16'h0000;
      last_chan_q   <= 8'h00;
    end else if (load && state_q == ST_MASTER) begin
      master_sent_q <= 1'b1;
      last_master_q <= master_q;
    end else if (load && state_q == ST_CHAN) begin
      chan_sent_q <= 1'b1;
      last_chan_q <= job_chan_q;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) flag_due_q <= 1'b0;
    else if (load && state_q == ST_DATA && !job_ts_q) flag_due_q <= 1'b1;
    else if (load && state_q == ST_FLAG) flag_due_q <= 1'b0;
  end

  always_comb begin
    pk_kind = PK_ERR;
    pk_size = SZ_8;
    pk_data = 32'h0000_0000;
    pk_tsv  = 1'b0;
    pk_ts   = '0;
    unique case (state_q)
      ST_MASTER: begin
        pk_kind = (master_q > 16'h00FF) ? PK_M16 : PK_M8;
        pk_size = (master_q > 16'h00FF) ? SZ_16 : SZ_8;
        pk_data = {16'h0000, master_q};
      end
      ST_CHAN: begin
        pk_kind = PK_C8;
        pk_data = {24'h000000, job_chan_q};
      end
      ST_DATA: begin
        if (job_marked_q) pk_kind = job_ts_q ? PK_DMTS : PK_DM;
        else pk_kind = job_ts_q ? PK_DTS : PK_D;
        pk_size = fit_size(job_word_q, squeeze, job_marked_q ? SZ_8 : SZ_32);
        pk_data = job_word_q;
        pk_tsv  = job_ts_q;
        pk_ts   = job_stamp_q;
      end
      ST_FLAG: begin
        pk_kind = PK_FLAG_TS;
        pk_tsv  = 1'b1;
        pk_ts   = i_timestamp;
      end
      default: pk_kind = PK_ERR;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pkt_valid    <= 1'b0;
      o_pkt_kind     <= PK_M8;
      o_pkt_size     <= SZ_4;
      o_pkt_data     <= 32'h0000_0000;
      o_pkt_ts_valid <= 1'b0;
      o_pkt_ts       <= '0;
    end else if (load) begin
      o_pkt_valid    <= 1'b1;
      o_pkt_kind     <= pk_kind;
      o_pkt_size     <= pk_size;
      o_pkt_data     <= pk_data;
      o_pkt_ts_valid <= pk_tsv;
      o_pkt_ts       <= pk_ts;
    end else if (i_pkt_ready) begin
      o_pkt_valid <= 1'b0;
    end
  end

  // ---------------- checks ----------------
  property p_master_pkt;
    @(posedge i_clock) disable iff (i_rst)
      (o_pkt_valid && (o_pkt_kind == PK_M8 || o_pkt_kind == PK_M16))
        |-> o_pkt_data[15:0] == last_master_q;
  endproperty
  a_master_pkt: assert property (p_master_pkt) else $error("master packet value wrong");

  property p_feat_count;
    @(posedge i_clock) disable iff (i_rst)
      (o_wb_ack && !i_wb_we && adr == `HET_OFF_FEAT) |-> o_wb_dat[23:15] == 9'(N_EVENTS);
  endproperty
  a_feat_count: assert property (p_feat_count) else $error("event count misreported");

  property p_idle_off;
    @(posedge i_clock) disable iff (i_rst)
      (!active && state_q == ST_IDLE) |=> state_q == ST_IDLE;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("trace started while disabled");

  property p_chan_range;
    @(posedge i_clock) disable iff (i_rst)
      (o_pkt_valid && o_pkt_kind == PK_C8) |-> o_pkt_data[31:3] == 29'h0;
  endproperty
  a_chan_range: assert property (p_chan_range) else $error("channel above 7");

  property p_order;
    @(posedge i_clock) disable iff (i_rst)
      (state_q == ST_DATA && free)
        |-> master_sent_q && chan_sent_q && last_chan_q == job_chan_q;
  endproperty
  a_order: assert property (p_order) else $error("data before master or channel");

  property p_cleared;
    @(posedge i_clock) disable iff (i_rst)
      (state_q == ST_DATA && free) |=> (pending & $past(job_mask_q) & ~$past(set)) == '0;
  endproperty
  a_cleared: assert property (p_cleared) else $error("reported event still pending");

  property p_lost;
    @(posedge i_clock) disable iff (i_rst)
      (|(set & pending & ~clr)) |=> lost;
  endproperty
  a_lost: assert property (p_lost) else $error("lost event not flagged");

  property p_flag;
    @(posedge i_clock) disable iff (i_rst)
      (state_q == ST_FLAG && free)
        |=> o_pkt_valid && o_pkt_kind == PK_FLAG_TS && o_pkt_ts_valid;
  endproperty
  a_flag: assert property (p_flag) else $error("flag packet missing");

  property p_short;
    @(posedge i_clock) disable iff (i_rst)
      (o_pkt_valid && o_pkt_size == SZ_4) |-> o_pkt_data[31:4] == 28'h0;
  endproperty
  a_short: assert property (p_short) else $error("short packet dropped set bits");

  c_data: cover property (@(posedge i_clock) o_pkt_valid && o_pkt_kind == PK_D);
  c_flag: cover property (@(posedge i_clock) o_pkt_valid && o_pkt_kind == PK_FLAG_TS);
  c_err:  cover property (@(posedge i_clock) o_pkt_valid && o_pkt_kind == PK_ERR);
  c_marked: cover property (@(posedge i_clock) o_pkt_valid && o_pkt_kind == PK_DMTS);
endmodule

/* File: hw/hw_event_trace_params.svh */
`ifndef HW_EVENT_TRACE_PARAMS_SVH
`define HW_EVENT_TRACE_PARAMS_SVH

// register byte offsets
`define HET_OFF_CTRL   8'h00
`define HET_OFF_MASTER 8'h04
`define HET_OFF_FEAT   8'h08
`define HET_OFF_EVEN   8'h0C
`define HET_OFF_TRIG   8'h10
`define HET_OFF_BANK   8'h14
`define HET_OFF_IDENT  8'h18
`define HET_OFF_GLOBAL 8'h1C
`define HET_OFF_STATUS 8'h20

// main control bits
`define HET_CTRL_EN     0
`define HET_CTRL_SQZ    1
`define HET_CTRL_LOST   2
`define HET_CTRL_TS     8
`define HET_CTRL_MARKED 9

// feature fields
`define HET_FEAT_COUNT_LSB 15
`define HET_FEAT_COMP_LSB  4
`define HET_FEAT_MWR       3
`define HET_FEAT_ERR       2
`define HET_FEAT_TRIG      0

`define HET_IDENT_CLASS    4'h1
`define HET_MASTER_RESET   16'h0000
`define HET_COMP_PROG      2'h3
`define HET_COMP_ALWAYS    2'h2
`define HET_MAX_EVENTS     256
`define HET_BANK_BITS      32

`endif

/* File: hw/hw_event_trace_pkg.sv */
package hw_event_trace_pkg;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_MASTER = 6'h02,
    ST_CHAN   = 6'h04,
    ST_DATA   = 6'h08,
    ST_FLAG   = 6'h10,
    ST_ERR    = 6'h20
  } state_t;

  typedef enum logic [3:0] {
    PK_M8 = 4'h0, PK_M16 = 4'h1, PK_C8 = 4'h2, PK_D = 4'h3, PK_DTS = 4'h4,
    PK_DM = 4'h5, PK_DMTS = 4'h6, PK_FLAG_TS = 4'h7, PK_ERR = 4'h8
  } pkt_kind_t;

  typedef enum logic [1:0] {SZ_4 = 2'h0, SZ_8 = 2'h1, SZ_16 = 2'h2, SZ_32 = 2'h3} pkt_size_t;

  typedef enum logic [1:0] {JOB_DATA = 2'h0, JOB_FLAG = 2'h1, JOB_ERR = 2'h2} job_t;

  function automatic pkt_size_t fit_size(input logic [31:0] v, input logic squeeze,
                                         input pkt_size_t full);
    if (!squeeze) return full;
    if (|v[31:16]) return SZ_32;
    if (|v[15:8]) return SZ_16;
    if (|v[7:4]) return SZ_8;
    return SZ_4;
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction

endpackage

/* File: hw/lowest_set.sv */
`timescale 1ns/100ps
module lowest_set #(
  parameter int W  = 32,
  parameter int IW = (W > 1) ? $clog2(W) : 1
) (
  input  wire logic [W-1:0]  i_vec,
  output logic      [IW-1:0] o_index,
  output logic               o_found
);
  always_comb begin
    o_index = '0;
    o_found = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      if (i_vec[i]) begin
        o_index = IW'(i);
        o_found = 1'b1;
      end
    end
  end
endmodule

/* File: hw/event_capture.sv */
`timescale 1ns/100ps
module event_capture #(
  parameter int NB   = 1,
  parameter int TS_W = 32
) (
  input  wire logic                 i_clock,
  input  wire logic                 i_rst,
  input  wire logic [NB*32-1:0]     i_set,
  input  wire logic [NB*32-1:0]     i_clr,
  input  wire logic                 i_lost_clr,
  input  wire logic [TS_W-1:0]      i_timestamp,
  output logic      [NB*32-1:0]     o_pending,
  output logic                      o_lost,
  output logic      [NB*TS_W-1:0]   o_stamp,
  output logic      [NB-1:0]        o_same
);
  // a new occurrence beats the clear of the packet that reports the old one
  always_ff @(posedge i_clock) begin
    if (i_rst) o_pending <= '0;
    else o_pending <= (o_pending & ~i_clr) | i_set;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) o_lost <= 1'b0;
    else o_lost <= (o_lost & ~i_lost_clr) | (|(i_set & o_pending & ~i_clr));
  end

  // a bank's stamp is exact only while all its pending bits arrived together
  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic any_set, was_empty;
    assign any_set   = |i_set[b*32 +: 32];
    assign was_empty = ~|(o_pending[b*32 +: 32] & ~i_clr[b*32 +: 32]);
    always_ff @(posedge i_clock) begin
      if (i_rst) begin
        o_stamp[b*TS_W +: TS_W] <= '0;
        o_same[b]               <= 1'b0;
      end else if (any_set) begin
        if (was_empty) o_stamp[b*TS_W +: TS_W] <= i_timestamp;
        o_same[b] <= was_empty;
      end
    end
  end
endmodule

/* File: tb/trace_sink.sv */
`timescale 1ns/100ps
module trace_sink (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_stall,
  input  wire logic        i_slow,
  input  wire logic        i_valid,
  input  wire logic [3:0]  i_kind,
  input  wire logic [1:0]  i_size,
  input  wire logic [31:0] i_data,
  input  wire logic        i_ts_valid,
  input  wire logic [31:0] i_ts,
  output logic             o_ready
);
  logic [3:0]  kinds[$];
  logic [1:0]  sizes[$];
  logic [31:0] datas[$];
  logic [31:0] stamps[$];
  // slow mode takes every other cycle so the encoder must hold its packet
  always_ff @(posedge i_clock) begin
    if (i_rst) o_ready <= 1'b0;
    else o_ready <= !i_stall && !(i_slow && o_ready);
  end
  always_ff @(posedge i_clock) begin
    if (!i_rst && i_valid && o_ready) begin
      kinds.push_back(i_kind);
      sizes.push_back(i_size);
      datas.push_back(i_data);
      stamps.push_back(i_ts_valid ? i_ts : 32'hFFFFFFFF);
    end
  end
endmodule

/* File: tb/hw_event_trace_encoder_bench.sv */
`timescale 1ns/100ps
module hw_event_trace_encoder_bench;
  import hw_event_trace_pkg::*;
  localparam int TMO = 200;
  logic        i_clock = 1'b0;
  logic        i_rst   = 1'b1;
  logic        req     = 1'b0;
  logic        we      = 1'b0;
  logic        stall   = 1'b0;
  logic        slow    = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] wdat    = 32'h0;
  logic [31:0] ev      = 32'h0;
  logic [31:0] ts      = 32'h0;
  logic [31:0] rdat;
  logic [31:0] pdata;
  logic [31:0] pts;
  logic [31:0] r;
  logic        ack;
  logic        pvalid;
  logic        ptsv;
  logic        ready;
  pkt_kind_t   pkind;
  pkt_size_t   psize;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          base = 0;

  always #25 i_clock = ~i_clock;

  hw_event_trace_encoder dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_wb_cyc(req), .i_wb_stb(req),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_event(ev), .i_timestamp(ts), .i_pkt_ready(ready), .o_pkt_valid(pvalid),
    .o_pkt_kind(pkind), .o_pkt_size(psize), .o_pkt_data(pdata), .o_pkt_ts_valid(ptsv),
    .o_pkt_ts(pts));

  trace_sink sink_u (.i_clock(i_clock), .i_rst(i_rst), .i_stall(stall), .i_slow(slow),
    .i_valid(pvalid), .i_kind(pkind), .i_size(psize), .i_data(pdata), .i_ts_valid(ptsv),
    .i_ts(pts), .o_ready(ready));

  task end_sim;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task tmo(input string nm);
    num_errors++;
    $display("mismatch %s expected answer seen none", nm);
    end_sim();
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge i_clock);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge i_clock);
      k++;
    end while (ack !== 1'b1 && k < TMO);
    q = rdat;
    req <= 1'b0;
    if (k >= TMO) tmo("bus ack");
  endtask

  task pulse(input logic [31:0] m, input int n);
    @(posedge i_clock);
    ev <= m;
    repeat (n) @(posedge i_clock);
    ev <= 32'h0;
  endtask

  task wait_pk(input int n);
    int k;
    k = 0;
    while (sink_u.kinds.size() < base + n && k < TMO) begin
      @(posedge i_clock);
      k++;
    end
    if (k >= TMO) tmo("packet count");
  endtask

  task pk(input int i, input pkt_kind_t k, input logic [31:0] d);
    chk("pkt kind", {28'h0, k}, {28'h0, sink_u.kinds[base+i]});
    chk("pkt data", d, sink_u.datas[base+i]);
  endtask

  task has(input pkt_kind_t k, input logic [31:0] d);
    logic f;
    f = 1'b0;
    for (int i = base; i < sink_u.kinds.size(); i++)
      if (sink_u.kinds[i] == k && (k == PK_ERR || sink_u.datas[i] == d)) f = 1'b1;
    chk("pkt present", 32'h1, {31'h0, f});
  endtask

  task t_regs;
    wb(1'b0, 8'h08, 32'h0, r);
    chk("features", 32'h0010003D, r);
    wb(1'b0, 8'h18, 32'h0, r);
    chk("ident class", 32'h1, {28'h0, r[3:0]});
    wb(1'b0, 8'h04, 32'h0, r);
    chk("master reset", 32'h0, r);
    wb(1'b0, 8'h00, 32'h0, r);
    chk("control reset", 32'h0, {31'h0, r[0]});
    wb(1'b1, 8'h14, 32'h1, r);
    wb(1'b0, 8'h14, 32'h0, r);
    chk("bank absent", 32'h0, r);
    wb(1'b0, 8'h40, 32'h0, r);
    chk("unmapped", 32'h0, r);
    wb(1'b1, 8'h04, 32'h1234, r);
    wb(1'b0, 8'h04, 32'h0, r);
    chk("master", 32'h1234, {16'h0, r[15:0]});
  endtask

  task t_plain;
    wb(1'b1, 8'h0C, 32'h20, r);
    wb(1'b1, 8'h00, 32'h1, r);
    wb(1'b1, 8'h1C, 32'h1, r);
    ts <= 32'h55;
    base = sink_u.kinds.size();
    pulse(32'h20, 1);
    wait_pk(4);
    pk(0, PK_M16, 32'h1234);
    pk(1, PK_C8, 32'h0);
    pk(2, PK_D, 32'h20);
    chk("size", {30'h0, SZ_32}, {30'h0, sink_u.sizes[base+2]});
    chk("data stamp", 32'hFFFFFFFF, sink_u.stamps[base+2]);
    pk(3, PK_FLAG_TS, 32'h0);
    chk("flag stamp", 32'h55, sink_u.stamps[base+3]);
    wb(1'b1, 8'h0C, 32'h1, r);
    base = sink_u.kinds.size();
    pulse(32'h21, 1);
    wait_pk(2);
    pk(0, PK_D, 32'h1);
  endtask

  task t_marked;
    wb(1'b1, 8'h00, 32'h303, r);
    wb(1'b1, 8'h0C, 32'h21, r);
    ts <= 32'h77;
    slow <= 1'b1;
    repeat (4) @(posedge i_clock);
    base = sink_u.kinds.size();
    pulse(32'h20, 1);
    repeat (3) @(posedge i_clock);
    ts <= 32'h99;
    wait_pk(1);
    pk(0, PK_DMTS, 32'h5);
    chk("size", {30'h0, SZ_4}, {30'h0, sink_u.sizes[base]});
    chk("stamp", 32'h77, sink_u.stamps[base]);
    slow <= 1'b0;
  endtask

  task t_lost;
    wb(1'b1, 8'h00, 32'h5, r);
    wb(1'b1, 8'h0C, 32'h20, r);
    base = sink_u.kinds.size();
    stall <= 1'b1;
    pulse(32'h20, 2);
    repeat (6) @(posedge i_clock);
    stall <= 1'b0;
    wait_pk(2);
    repeat (20) @(posedge i_clock);
    has(PK_ERR, 32'h0);
    has(PK_D, 32'h20);
    wb(1'b0, 8'h20, 32'h0, r);
    chk("lost cleared", 32'h0, {31'h0, r[0]});
  endtask

  task t_stamp;
    wb(1'b1, 8'h00, 32'h101, r);
    wb(1'b1, 8'h0C, 32'h21, r);
    ts <= 32'h40;
    base = sink_u.kinds.size();
    pulse(32'h21, 1);
    wait_pk(1);
    pk(0, PK_DTS, 32'h21);
    chk("dts stamp", 32'h40, sink_u.stamps[base]);
    repeat (10) @(posedge i_clock);
    chk("no flag", base + 1, sink_u.kinds.size());
  endtask

  task t_gated;
    wb(1'b1, 8'h1C, 32'h0, r);
    base = sink_u.kinds.size();
    pulse(32'h20, 1);
    repeat (20) @(posedge i_clock);
    chk("gated count", base, sink_u.kinds.size());
  endtask

  initial begin
    repeat (4) @(posedge i_clock);
    i_rst <= 1'b0;
    t_regs();
    t_plain();
    t_marked();
    t_lost();
    t_stamp();
    t_gated();
    end_sim();
  end
endmodule
